// ---- src/rws_map.vh ----
// Function
// - status bit 7 mirrors the core's global interrupt enable, read only.
// - watchdog reset sets status bit 5; software may clear, never set.
// - power-up reset sets status bit 4; software may clear, never set.
// - watchdog disabled while power-up flag set; clearing it enables it for good.
// - writing 1 to status bit 3 sleeps until unmasked interrupt or reset.
// - writing 1 to status bit 0 halts the core until a reset.
// - power-up reset loads status register with only the power-up flag set.
// - after power-up, hold core off about 20 ms before first fetch.
// - watchdog counts sleep-timer overflows, resets at count three.
// - sleep timer on 32 kHz clock interrupts on each period overflow.
// - any watchdog-clear write clears watchdog; value 0x38 also clears sleep timer.
// - sleep wakes on any unmasked pending interrupt, ignoring global enable.
// - sleep is left only while the halt bit is clear.
// - on wake force internal clock; oscillator restarts, two slow cycles recovery.
// - after wake the core runs the next instruction before any handler.
// - setting sleep raises halt request at once; core samples on its rising edge.
// - after halt grant, wait core clock falling edge, then raise power-down.
// - power-down strobe turns off flash, fast oscillator, filter and bandgap.
// - wake interrupt synced on slow falling edge; power-down drops next rising edge.
// - next slow rising edge samples monitors; following falling edge drops halt request.
// - during sleep the voltage detector runs duty cycled.
// - duty setting 00,01,10,11 gives 1/128, 1/512, 1/32, 1/8 on-time.
`ifndef RWS_MAP_VH
`define RWS_MAP_VH

// register indices, byte address is four times the index
`define RWS_IDX_WDT_CLEAR     10'h0e3
`define RWS_IDX_STATUS        10'h0ff
`define RWS_IDX_MON_CMP       10'h1e4
`define RWS_IDX_MON_DUTY      10'h1eb
`define RWS_IDX_SLEEP_PERIOD  10'h1f0

// status and monitor duty register fields
`define RWS_SCR_GLOBAL_IRQ_ENABLED_STATUS_BIT      7
`define RWS_SCR_WATCHDOG_RESET_FLAG_BIT      5
`define RWS_SCR_POWER_UP_RESET_FLAG_BIT      4
`define RWS_SCR_SLEEP_BIT     3
`define RWS_SCR_STOP_BIT      0
`define RWS_SCR_RESET         8'h10
`define RWS_DUTY_HI           7
`define RWS_DUTY_LO           6

// special data values
`define RWS_WDT_CLR_TIMER     8'h38
`define RWS_WDT_FIRE_COUNT    2'h3

// timing
`define RWS_CLK_HZ            10000000
`define RWS_HOLDOFF_MS        20
`define RWS_HOLDOFF_CYCLES    ((`RWS_HOLDOFF_MS * `RWS_CLK_HZ) / 1000)

// axi responses
`define RWS_RESP_OKAY         2'h0
`define RWS_RESP_SLVERR       2'h2

`endif

// ---- src/rws_sleep_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "rws_map.vh"

module rws_sleep_timer (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // control
    input  wire        lp_rise,
    input  wire [1:0]  period_sel,
    input  wire        clear_timer,
    input  wire        clear_wdt,
    input  wire        wdt_enable,
    // events
    output reg         overflow_reg,
    output reg         wdt_fire_reg
);

    reg  [14:0] count_reg;
    reg  [1:0]  wdt_count_reg;
    wire        at_end;

    // period in slow-clock ticks, minus one
    function [14:0] period_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    period_last = 15'h003f;
                2'h1:    period_last = 15'h01ff;
                2'h2:    period_last = 15'h0fff;
                default: period_last = 15'h7fff;
            endcase
        end
    endfunction

    assign at_end = lp_rise && (count_reg == period_last(period_sel));

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg     <= 15'h0000;
            wdt_count_reg <= 2'h0;
            overflow_reg  <= 1'b0;
            wdt_fire_reg  <= 1'b0;
        end else begin
            overflow_reg <= 1'b0;
            wdt_fire_reg <= 1'b0;
            if (clear_timer || at_end) begin
                count_reg <= 15'h0000;
            end else if (lp_rise) begin
                count_reg <= count_reg + 15'h0001;
            end
            if (at_end && !clear_timer) begin
                overflow_reg <= 1'b1;
            end
            if (clear_wdt || !wdt_enable) begin
                wdt_count_reg <= 2'h0;
            end else if (at_end) begin
                if (wdt_count_reg == (`RWS_WDT_FIRE_COUNT - 2'h1)) begin
                    wdt_count_reg <= 2'h0;
                    wdt_fire_reg  <= 1'b1;
                end else begin
                    wdt_count_reg <= wdt_count_reg + 2'h1;
                end
            end
        end
    end

endmodule // rws_sleep_timer

`default_nettype wire

// ---- src/rws_top.v ----
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "rws_map.vh"

module rws_top #(
    parameter integer HOLDOFF_CYCLES = `RWS_HOLDOFF_CYCLES
) (
    // clock and reset
    input  wire        clk,
    input  wire        nrst,
    // axi4-lite write address
    input  wire [11:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [11:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // core side
    input  wire        core_clock,
    input  wire        global_irq_enable,
    input  wire        halt_grant,
    input  wire [7:0]  irq_pending,
    input  wire [7:0]  irq_mask,
    output reg         halt_request,
    output reg         core_stop,
    output reg         core_hold,
    output reg         clock_force_internal,
    output reg         sleep_timer_irq,
    output reg         watchdog_reset_event,
    // power side
    input  wire        lp_clock,
    input  wire        ext_reset,
    input  wire        low_voltage_detector,
    input  wire        ppor_comparator,
    output reg         power_down_strobe,
    output reg         monitor_enable
);

    // sleep sequencer states
    localparam [6:0] ST_RUN   = 7'h01;
    localparam [6:0] ST_REQ   = 7'h02;
    localparam [6:0] ST_GRANT = 7'h04;
    localparam [6:0] ST_SLEEP = 7'h08;
    localparam [6:0] ST_WK_PD = 7'h10;
    localparam [6:0] ST_WK_SM = 7'h20;
    localparam [6:0] ST_WK_BR = 7'h40;

    reg  [6:0]  state_reg;
    reg  [6:0]  state_next;
    reg         watchdog_reset_flag_reg;
    reg         power_up_reset_flag_reg;
    reg         sleep_reg;
    reg         stop_reg;
    reg  [1:0]  duty_reg;
    reg  [1:0]  period_reg;
    reg  [1:0]  mon_cmp_reg;
    reg  [8:0]  duty_cnt_reg;
    reg  [17:0] hold_cnt_reg;
    reg         lp_prev_reg;
    reg         core_prev_reg;
    reg         aw_full_reg;
    reg         w_full_reg;
    reg  [11:0] aw_addr_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg  [31:0] rd_data;
    reg         rd_ok;
    wire        lp_rise;
    wire        lp_fall;
    wire        core_fall;
    wire        aw_take;
    wire        w_take;
    wire        wr_do;
    wire        wr_lane0;
    wire        wr_ok;
    wire        wr_scr;
    wire        wr_wdt;
    wire        sleep_write;
    wire        soft_reset;
    wire        wake_cond;
    wire        tmr_overflow;
    wire        wdt_fire;

    // word address hits a register index
    function hit;
        input [11:0] addr;
        input [9:0]  idx;
        begin
            hit = (addr == {idx, 2'b00});
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = hit(addr, `RWS_IDX_WDT_CLEAR) || hit(addr, `RWS_IDX_STATUS) ||
                     hit(addr, `RWS_IDX_MON_CMP) || hit(addr, `RWS_IDX_MON_DUTY) ||
                     hit(addr, `RWS_IDX_SLEEP_PERIOD);
        end
    endfunction

    // on-time period count, minus one
    function [8:0] duty_last;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    duty_last = 9'h07f;
                2'h1:    duty_last = 9'h1ff;
                2'h2:    duty_last = 9'h01f;
                default: duty_last = 9'h007;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // slow and core clocks are sampled as plain inputs
    assign lp_rise   = lp_clock && !lp_prev_reg;
    assign lp_fall   = !lp_clock && lp_prev_reg;
    assign core_fall = !core_clock && core_prev_reg;

    assign aw_take     = s_axi_awvalid && s_axi_awready;
    assign w_take      = s_axi_wvalid && s_axi_wready;
    assign wr_do       = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_lane0    = wr_do && w_strb_reg[0];
    assign wr_ok       = mapped(aw_addr_reg);
    assign wr_scr      = wr_lane0 && hit(aw_addr_reg, `RWS_IDX_STATUS);
    assign wr_wdt      = wr_lane0 && hit(aw_addr_reg, `RWS_IDX_WDT_CLEAR);
    assign sleep_write = wr_scr && w_data_reg[`RWS_SCR_SLEEP_BIT];
    assign soft_reset  = wdt_fire || ext_reset;
    assign wake_cond   = |(irq_pending & irq_mask);

    rws_sleep_timer u_timer (
        .clk          (clk),
        .nrst         (nrst),
        .lp_rise      (lp_rise),
        .period_sel   (period_reg),
        .clear_timer  (wr_wdt && (w_data_reg[7:0] == `RWS_WDT_CLR_TIMER)),
        .clear_wdt    (wr_wdt),
        .wdt_enable   (!power_up_reset_flag_reg),
        .overflow_reg (tmr_overflow),
        .wdt_fire_reg (wdt_fire)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi write channel
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            aw_addr_reg   <= 12'h000;
            w_data_reg    <= 32'h00000000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RWS_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_full_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_full_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RWS_RESP_OKAY : `RWS_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel
    always @* begin
        rd_data = 32'h00000000;
        rd_ok   = 1'b1;
        if (hit(s_axi_araddr, `RWS_IDX_STATUS)) begin
            rd_data[`RWS_SCR_GLOBAL_IRQ_ENABLED_STATUS_BIT]  = global_irq_enable;
            rd_data[`RWS_SCR_WATCHDOG_RESET_FLAG_BIT]  = watchdog_reset_flag_reg;
            rd_data[`RWS_SCR_POWER_UP_RESET_FLAG_BIT]  = power_up_reset_flag_reg;
            rd_data[`RWS_SCR_SLEEP_BIT] = sleep_reg;
            rd_data[`RWS_SCR_STOP_BIT]  = stop_reg;
        end else if (hit(s_axi_araddr, `RWS_IDX_MON_CMP)) begin
            rd_data[1:0] = mon_cmp_reg;
        end else if (hit(s_axi_araddr, `RWS_IDX_MON_DUTY)) begin
            rd_data[`RWS_DUTY_HI:`RWS_DUTY_LO] = duty_reg;
        end else if (hit(s_axi_araddr, `RWS_IDX_SLEEP_PERIOD)) begin
            rd_data[1:0] = period_reg;
        end else if (!hit(s_axi_araddr, `RWS_IDX_WDT_CLEAR)) begin
            rd_ok = 1'b0;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RWS_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_data;
                s_axi_rresp   <= rd_ok ? `RWS_RESP_OKAY : `RWS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and configuration registers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_reset_flag_reg   <= 1'b0;
            power_up_reset_flag_reg   <= 1'b1;
            sleep_reg  <= 1'b0;
            stop_reg   <= 1'b0;
            duty_reg   <= 2'h0;
            period_reg <= 2'h0;
        end else begin
            if (wr_scr) begin
                if (!w_data_reg[`RWS_SCR_POWER_UP_RESET_FLAG_BIT]) begin
                    power_up_reset_flag_reg <= 1'b0;
                end
                if (!w_data_reg[`RWS_SCR_WATCHDOG_RESET_FLAG_BIT]) begin
                    watchdog_reset_flag_reg <= 1'b0;
                end
                if (w_data_reg[`RWS_SCR_STOP_BIT]) begin
                    stop_reg <= 1'b1;
                end
                if (w_data_reg[`RWS_SCR_SLEEP_BIT]) begin
                    sleep_reg <= 1'b1;
                end
            end
            if (wr_lane0 && hit(aw_addr_reg, `RWS_IDX_MON_DUTY)) begin
                duty_reg <= w_data_reg[`RWS_DUTY_HI:`RWS_DUTY_LO];
            end
            if (wr_lane0 && hit(aw_addr_reg, `RWS_IDX_SLEEP_PERIOD)) begin
                period_reg <= w_data_reg[1:0];
            end
            // sleep bit drops when the wake sequence ends
            if (state_reg == ST_WK_BR && lp_fall) begin
                sleep_reg <= 1'b0;
            end
            // set wins over a same-cycle clear
            if (wdt_fire) begin
                watchdog_reset_flag_reg <= 1'b1;
            end
            if (soft_reset) begin
                sleep_reg <= 1'b0;
                stop_reg  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep and wake sequencer
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (sleep_write && !halt_grant) begin
                    state_next = ST_REQ;
                end
            end
            ST_REQ: begin
                if (halt_grant) begin
                    state_next = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (core_fall) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // wake synced on slow falling edge
                if (lp_fall && wake_cond && !stop_reg) begin
                    state_next = ST_WK_PD;
                end
            end
            ST_WK_PD: begin
                if (lp_rise) begin
                    state_next = ST_WK_SM;
                end
            end
            ST_WK_SM: begin
                if (lp_rise) begin
                    state_next = ST_WK_BR;
                end
            end
            ST_WK_BR: begin
                if (lp_fall) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg            <= ST_RUN;
            halt_request         <= 1'b0;
            power_down_strobe    <= 1'b0;
            clock_force_internal <= 1'b0;
            mon_cmp_reg          <= 2'h0;
        end else if (soft_reset) begin
            state_reg            <= ST_RUN;
            halt_request         <= 1'b0;
            power_down_strobe    <= 1'b0;
            clock_force_internal <= 1'b0;
        end else begin
            state_reg            <= state_next;
            clock_force_internal <= 1'b0;
            if (state_reg == ST_RUN && state_next == ST_REQ) begin
                halt_request <= 1'b1;
            end
            if (state_reg == ST_GRANT && state_next == ST_SLEEP) begin
                power_down_strobe <= 1'b1;
            end
            // strobe drops on next rising edge
            if (state_reg == ST_WK_PD && lp_rise) begin
                power_down_strobe    <= 1'b0;
                clock_force_internal <= 1'b1;
            end
            if (state_reg == ST_WK_SM && lp_rise) begin
                mon_cmp_reg <= {low_voltage_detector, ppor_comparator};
            end
            if (state_reg == ST_WK_BR && lp_fall) begin
                halt_request <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitor duty cycling, power-up hold-off and misc outputs
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lp_prev_reg          <= 1'b0;
            core_prev_reg        <= 1'b0;
            duty_cnt_reg         <= 9'h000;
            monitor_enable       <= 1'b1;
            hold_cnt_reg         <= 18'h00000;
            core_hold            <= 1'b1;
            core_stop            <= 1'b0;
            sleep_timer_irq      <= 1'b0;
            watchdog_reset_event <= 1'b0;
        end else begin
            lp_prev_reg   <= lp_clock;
            core_prev_reg <= core_clock;
            // one slow period on per window
            if (state_reg != ST_SLEEP) begin
                duty_cnt_reg   <= 9'h000;
                monitor_enable <= 1'b1;
            end else if (lp_rise) begin
                if (duty_cnt_reg >= duty_last(duty_reg)) begin
                    duty_cnt_reg <= 9'h000;
                end else begin
                    duty_cnt_reg <= duty_cnt_reg + 9'h001;
                end
                monitor_enable <= (duty_cnt_reg >= duty_last(duty_reg));
            end
            if (core_hold) begin
                if (hold_cnt_reg >= HOLDOFF_CYCLES[17:0] - 18'h00001) begin
                    core_hold <= 1'b0;
                end else begin
                    hold_cnt_reg <= hold_cnt_reg + 18'h00001;
                end
            end
            core_stop            <= stop_reg && !soft_reset;
            sleep_timer_irq      <= tmr_overflow;
            watchdog_reset_event <= wdt_fire;
        end
    end

endmodule // rws_top

`default_nettype wire

// ---- tb/rws_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module rws_props #(parameter integer HOLDOFF_CYCLES = 20) (
    // clock, reset and core inputs
    input wire logic clk, nrst, ext_reset, halt_grant,
    // watched outputs
    input wire logic halt_request, power_down_strobe, clock_force_internal,
    input wire logic monitor_enable, watchdog_reset_event, sleep_timer_irq, core_hold
);
    // saturates, so long runs never wrap back into the holdoff span
    logic [31:0] hold_cnt_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            hold_cnt_reg <= '0;
        else if (hold_cnt_reg < HOLDOFF_CYCLES + 4)
            hold_cnt_reg <= hold_cnt_reg + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_granted;
        halt_request && halt_grant;
    endsequence
    property p_pd_grant;
        $rose(power_down_strobe) |-> s_granted;
    endproperty
    a_pd_grant: assert property (p_pd_grant) else $error("power down without grant");
    property p_pd_req;
        power_down_strobe |-> halt_request;
    endproperty
    a_pd_req: assert property (p_pd_req) else $error("power down without request");
    property p_cfi;
        clock_force_internal |-> $fell(power_down_strobe);
    endproperty
    a_cfi: assert property (p_cfi) else $error("clock force not at power up");
    property p_mon;
        !halt_request && !$past(halt_request) |-> monitor_enable;
    endproperty
    a_mon: assert property (p_mon) else $error("monitor off while awake");
    property p_pd_stand;
        $rose(power_down_strobe) && !ext_reset |=> power_down_strobe[*4];
    endproperty
    a_pd_stand: assert property (p_pd_stand) else $error("power down dropped early");
    property p_irq;
        sleep_timer_irq |=> !sleep_timer_irq[*8];
    endproperty
    a_irq: assert property (p_irq) else $error("timer irq not a pulse");
    property p_wdr;
        watchdog_reset_event |=> !watchdog_reset_event[*8];
    endproperty
    a_wdr: assert property (p_wdr) else $error("watchdog event not a pulse");
    property p_hold;
        core_hold ? hold_cnt_reg <= HOLDOFF_CYCLES + 1 : hold_cnt_reg >= HOLDOFF_CYCLES - 1;
    endproperty
    a_hold: assert property (p_hold) else $error("core hold span wrong");
endmodule // rws_props
bind rws_top rws_props #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_props (
    .clk, .nrst, .ext_reset, .halt_grant, .halt_request, .power_down_strobe, .clock_force_internal,
    .monitor_enable, .watchdog_reset_event, .sleep_timer_irq, .core_hold);
`default_nettype wire

// ---- tb/rws_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rws_core_model (
    // clock and reset
    input wire logic  clk,
    input wire logic  nrst,
    // slow mode stretches the grant delay
    input wire logic  slow,
    input wire logic  halt_request,
    output var logic  core_clock,
    output var logic  halt_grant
);
    logic [3:0] div_reg;
    logic       seen_reg;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_reg <= '0;
            core_clock <= 1'b0;
        end else begin
            div_reg <= div_reg + 4'h1;
            core_clock <= slow ? div_reg[3] : div_reg[1];
        end
    end
    always @(posedge core_clock or negedge nrst) begin
        if (!nrst) begin
            seen_reg <= 1'b0;
            halt_grant <= 1'b0;
        end else begin
            seen_reg <= halt_request;
            halt_grant <= seen_reg & halt_request;
        end
    end
endmodule // rws_core_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rws_map.vh"
module tb_top;
    logic        clk, nrst, slow, global_irq_enable, ext_reset, lp_clock, halt_grant, core_clock;
    logic        low_voltage_detector, ppor_comparator;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0]  irq_pending, irq_mask;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        halt_request, core_stop, core_hold, clock_force_internal, monitor_enable;
    logic        sleep_timer_irq, watchdog_reset_event, power_down_strobe;
    int          failures, num_checks, n_irq, base, i;
    rws_top #(.HOLDOFF_CYCLES(20)) dut (
        .clk, .nrst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .core_clock, .global_irq_enable, .halt_grant, .irq_pending,
        .irq_mask, .halt_request, .core_stop, .core_hold, .clock_force_internal, .sleep_timer_irq,
        .watchdog_reset_event, .lp_clock, .ext_reset, .low_voltage_detector, .ppor_comparator,
        .power_down_strobe, .monitor_enable);
    rws_core_model u_core (.clk, .nrst, .slow, .halt_request, .core_clock, .halt_grant);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    // off phase from clk on purpose
    initial begin
        lp_clock = 0;
        #7;
        forever #15625 lp_clock = ~lp_clock;
    end
    always @(posedge clk) begin
        if (sleep_timer_irq === 1'b1) n_irq <= n_irq + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask
    task rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk(s_axi_rdata, {24'h0, ed});
        chk(s_axi_rresp, er);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #10_000_000;
        failures++;
        give_verdict;
    end
    initial begin
        {nrst, slow, global_irq_enable, ext_reset, low_voltage_detector, ppor_comparator} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_pending, irq_mask} = '0;
        repeat (8) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        chk(core_hold, 1);
        repeat (30) @(posedge clk);
        chk(core_hold, 0);
        rd(`RWS_IDX_STATUS, 8'h10, `RWS_RESP_OKAY);
        global_irq_enable <= 1;
        rd(`RWS_IDX_STATUS, 8'h90, `RWS_RESP_OKAY);
        wr(`RWS_IDX_STATUS, 8'h70, `RWS_RESP_OKAY);
        rd(`RWS_IDX_STATUS, 8'h90, `RWS_RESP_OKAY);
        rd(10'h001, 8'h00, `RWS_RESP_SLVERR);
        rd(`RWS_IDX_WDT_CLEAR, 8'h00, `RWS_RESP_OKAY);
        // sleep with interrupts globally off and a slow core
        global_irq_enable <= 0;
        slow <= 1;
        irq_mask <= 8'h01;
        ppor_comparator <= 1;
        wr(`RWS_IDX_STATUS, 8'h18, `RWS_RESP_OKAY);
        chk(halt_request, 1);
        for (i = 0; i < 3000 && !power_down_strobe; i++) @(posedge clk);
        chk(halt_grant, 1);
        irq_pending <= 8'h02;
        repeat (800) @(posedge clk);
        chk(power_down_strobe, 1);
        chk(monitor_enable, 0);
        irq_pending <= 8'h01;
        for (i = 0; i < 3000 && halt_request; i++) @(posedge clk);
        chk(halt_request, 0);
        chk(power_down_strobe, 0);
        irq_pending <= 8'h00;
        rd(`RWS_IDX_MON_CMP, 8'h01, `RWS_RESP_OKAY);
        rd(`RWS_IDX_STATUS, 8'h10, `RWS_RESP_OKAY);
        wr(`RWS_IDX_STATUS, 8'h11, `RWS_RESP_OKAY);
        @(posedge clk);
        chk(core_stop, 1);
        ext_reset <= 1;
        @(posedge clk);
        ext_reset <= 0;
        repeat (2) @(posedge clk);
        chk(core_stop, 0);
        wr(`RWS_IDX_STATUS, 8'h00, `RWS_RESP_OKAY);
        wr(`RWS_IDX_STATUS, 8'h30, `RWS_RESP_OKAY);
        rd(`RWS_IDX_STATUS, 8'h00, `RWS_RESP_OKAY);
        wr(`RWS_IDX_WDT_CLEAR, `RWS_WDT_CLR_TIMER, `RWS_RESP_OKAY);
        base = n_irq;
        for (i = 0; i < 70000 && !watchdog_reset_event; i++) @(posedge clk);
        @(posedge clk);
        chk(n_irq - base, 3);
        rd(`RWS_IDX_STATUS, 8'h20, `RWS_RESP_OKAY);
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
